// ---- sbp_pkg.sv ----
package sbp_pkg;
    // Clock period of mclk
    localparam int CLK_PERIOD_NS = 8;
    // Short arbitrated bus reset length
    localparam int SHORT_RST_NS = 1300;
    localparam int SHORT_RST_CYC =
        (SHORT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Long bus reset length
    localparam int LONG_RST_US = 166;
    localparam int LONG_RST_CYC =
        (LONG_RST_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Field widths
    localparam int PAGE_W = 3;
    localparam int PORT_W = 4;
    localparam int PAGE_ROWS = 8;
    localparam int ROW_W = 8;
    localparam int NPORTS_DEF = 1;
    // Event flag bit positions in the flag vector
    localparam int FLAG_N = 4;
    localparam int LOOP_BIT = 0;
    localparam int PWR_BIT = 1;
    localparam int TMO_BIT = 2;
    localparam int PEVT_BIT = 3;
    // System reset values
    localparam logic [FLAG_N-1:0] FLAGS_RST = 4'h0;
    localparam logic [PAGE_W-1:0] PAGE_RST = 3'h0;
    localparam logic [PORT_W-1:0] PORT_RST = 4'h0;
    localparam logic ACCEL_RST = 1'b0;
    localparam logic MULTI_RST = 1'b0;
    localparam logic [PAGE_W-1:0] STATUS_PAGE = 3'h0;
endpackage

// ---- sbp_sync.sv ----
`timescale 1ns/1ps
module sbp_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Asynchronous in, synchronised out
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_r;

    always_ff @(posedge mclk) begin
        if (rst) begin
            meta_r <= '0;
            sync_out <= '0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

// ---- sbp_rst_timer.sv ----
`timescale 1ns/1ps
module sbp_rst_timer #(
    parameter int SHORT_CYC = 163,
    parameter int LONG_CYC = 20750
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Start request
    input wire logic start,
    input wire logic start_short,
    // Reset in progress
    output logic active_r,
    output logic short_r
);
    localparam int CW = $clog2(LONG_CYC + 1);
    localparam logic [CW-1:0] SHORT_LD = CW'(SHORT_CYC - 1);
    localparam logic [CW-1:0] LONG_LD = CW'(LONG_CYC - 1);

    logic [CW-1:0] count_r;

    // A new start restarts the count, even mid-reset
    always_ff @(posedge mclk) begin
        if (rst) begin
            count_r <= '0;
            active_r <= 1'b0;
            short_r <= 1'b0;
        end else if (start) begin
            count_r <= start_short ? SHORT_LD : LONG_LD;
            active_r <= 1'b1;
            short_r <= start_short;
        end else if (active_r) begin
            if (count_r == '0) begin
                active_r <= 1'b0;
            end else begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule

// ---- sbp_base_ctrl.sv ----
`timescale 1ns/1ps
module sbp_base_ctrl
    import sbp_pkg::*;
#(
    parameter int NPORTS = NPORTS_DEF,
    parameter int LONG_CYC = LONG_RST_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Software writes
    input wire logic sw_short_req_wr,
    input wire logic sw_short_req_data,
    input wire logic sw_flag_wr,
    input wire logic [FLAG_N-1:0] sw_flag_data,
    input wire logic sw_cfg_wr,
    input wire logic cfg_accel_in,
    input wire logic cfg_multi_in,
    input wire logic [PAGE_W-1:0] cfg_page_in,
    input wire logic [PORT_W-1:0] cfg_port_in,
    input wire logic watchdog_en,
    // Pins
    input wire logic cable_supply_sense,
    input wire logic link_power_status,
    // Arbitration and bus state
    input wire logic reset_opportunity,
    input wire logic legacy_phy_present,
    input wire logic peer_bus_reset,
    input wire logic arb_tree_timeout,
    input wire logic state_timeout,
    // Port status
    input wire logic [NPORTS-1:0] port_bias,
    input wire logic [NPORTS-1:0] port_con,
    input wire logic [NPORTS-1:0] port_dis,
    input wire logic [NPORTS-1:0] port_fault,
    input wire logic [NPORTS-1:0] port_int_en,
    input wire logic bias_report_dis,
    input wire logic [NPORTS-1:0] resume_start,
    // Status page read
    input wire logic [2:0] port_page_addr,
    input wire logic [NPORTS*PAGE_ROWS*ROW_W-1:0] port_page_rows,
    output logic [ROW_W-1:0] port_page_rdata_r,
    // Register state
    output logic short_reset_request_r,
    output logic [FLAG_N-1:0] flags_r,
    output logic enab_accel_r,
    output logic enab_multi_r,
    output logic [PAGE_W-1:0] page_sel_r,
    output logic [PORT_W-1:0] port_sel_r,
    // Bus reset and link
    output logic bus_reset_active,
    output logic bus_reset_short,
    output logic bus_reset_start,
    output logic link_wake_r
);
    logic sense_s;
    logic lps_s;
    logic sense_d_r;
    logic sense_fall;
    logic short_launch;
    logic timer_start;
    logic timer_short;
    logic [NPORTS-1:0] bias_d_r;
    logic [NPORTS-1:0] con_d_r;
    logic [NPORTS-1:0] dis_d_r;
    logic [NPORTS-1:0] fault_d_r;
    logic [NPORTS-1:0] port_chg;
    logic port_evt;
    logic [FLAG_N-1:0] flag_set;
    logic [FLAG_N-1:0] flag_clr;
    logic [FLAG_N-1:0] flags_nxt;
    logic [ROW_W-1:0] rdata_nxt;

    // Set beats a same-cycle clear; only written ones clear
    function automatic logic w1c(input logic cur, input logic set,
                                 input logic clr);
        return set | (cur & ~clr);
    endfunction

    function automatic logic [ROW_W-1:0] row_pick(
        input logic [NPORTS*PAGE_ROWS*ROW_W-1:0] rows,
        input logic [PORT_W-1:0] port,
        input logic [2:0] addr);
        int idx;
        idx = (int'(port) * PAGE_ROWS + int'(addr)) * ROW_W;
        return rows[idx +: ROW_W];
    endfunction

    sbp_sync #(
        .W(2)
    ) u_sync (
        .mclk(mclk),
        .rst(rst),
        .async_in({cable_supply_sense, link_power_status}),
        .sync_out({sense_s, lps_s})
    );

    // Short request waits for an opportunity and for any reset to end
    assign short_launch = short_reset_request_r & reset_opportunity &
                          ~bus_reset_active;
    assign timer_start = state_timeout | short_launch;
    assign timer_short = ~state_timeout & ~legacy_phy_present;
    assign bus_reset_start = timer_start | peer_bus_reset;

    sbp_rst_timer #(
        .SHORT_CYC(SHORT_RST_CYC),
        .LONG_CYC(LONG_CYC)
    ) u_timer (
        .mclk(mclk),
        .rst(rst),
        .start(timer_start),
        .start_short(timer_short),
        .active_r(bus_reset_active),
        .short_r(bus_reset_short)
    );

    // A software write in the clearing cycle wins: the request takes the written value
    always_ff @(posedge mclk) begin
        if (rst) begin
            short_reset_request_r <= 1'b0;
        end else if (sw_short_req_wr) begin
            short_reset_request_r <= sw_short_req_data;
        end else if (bus_reset_start) begin
            short_reset_request_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            sense_d_r <= 1'b0;
        end else begin
            sense_d_r <= sense_s;
        end
    end
    assign sense_fall = sense_d_r & ~sense_s;

    always_ff @(posedge mclk) begin
        if (rst) begin
            bias_d_r <= '0;
            con_d_r <= '0;
            dis_d_r <= '0;
            fault_d_r <= '0;
        end else begin
            bias_d_r <= port_bias;
            con_d_r <= port_con;
            dis_d_r <= port_dis;
            fault_d_r <= port_fault;
        end
    end

    // Changes against last cycle's levels; bias masked when not reported
    assign port_chg = ((port_bias ^ bias_d_r) & {NPORTS{~bias_report_dis}})
                    | (port_con ^ con_d_r) | (port_dis ^ dis_d_r)
                    | (port_fault ^ fault_d_r);
    assign port_evt = |(port_chg & port_int_en)
                    | (watchdog_en & |resume_start);

    always_comb begin
        flag_set = '0;
        flag_set[LOOP_BIT] = arb_tree_timeout;
        flag_set[PWR_BIT] = sense_fall;
        flag_set[TMO_BIT] = state_timeout;
        flag_set[PEVT_BIT] = port_evt;
        flag_clr = sw_flag_wr ? sw_flag_data : '0;
        for (int i = 0; i < FLAG_N; i++) begin
            flags_nxt[i] = w1c(flags_r[i], flag_set[i], flag_clr[i]);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            flags_r <= FLAGS_RST;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // Held as a level so a link going inactive later is woken too
    always_ff @(posedge mclk) begin
        if (rst) begin
            link_wake_r <= 1'b0;
        end else begin
            link_wake_r <= flags_r[LOOP_BIT] & watchdog_en & ~lps_s;
        end
    end

    // Bus reset never touches these
    always_ff @(posedge mclk) begin
        if (rst) begin
            enab_accel_r <= ACCEL_RST;
            enab_multi_r <= MULTI_RST;
            page_sel_r <= PAGE_RST;
            port_sel_r <= PORT_RST;
        end else if (sw_cfg_wr) begin
            enab_accel_r <= cfg_accel_in;
            enab_multi_r <= cfg_multi_in;
            page_sel_r <= cfg_page_in;
            port_sel_r <= cfg_port_in;
        end
    end

    always_comb begin
        rdata_nxt = '0;
        if (page_sel_r == STATUS_PAGE && int'(port_sel_r) < NPORTS) begin
            rdata_nxt = row_pick(port_page_rows, port_sel_r,
                                 port_page_addr);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            port_page_rdata_r <= '0;
        end else begin
            port_page_rdata_r <= rdata_nxt;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_short_go: assert property (
        short_launch && !state_timeout |=> bus_reset_active
            && bus_reset_short == !$past(legacy_phy_present))
        else $error("short reset request not launched correctly");
    a_short_clear: assert property (
        bus_reset_start && !sw_short_req_wr |=> !short_reset_request_r)
        else $error("short reset request survived bus reset");
    a_short_hold: assert property (
        short_reset_request_r && !bus_reset_start && !sw_short_req_wr
            |=> short_reset_request_r)
        else $error("short reset request dropped before a bus reset");
    a_loop_set: assert property (
        arb_tree_timeout |=> flags_r[LOOP_BIT])
        else $error("loop flag not set on tree-ID time-out");
    a_loop_quiet: assert property (
        !flags_r[LOOP_BIT] && !arb_tree_timeout |=> !flags_r[LOOP_BIT])
        else $error("loop flag set without a tree-ID time-out");
    a_flag_w1c: assert property (
        sw_flag_wr && sw_flag_data[PWR_BIT] && !sense_fall
            |=> !flags_r[PWR_BIT])
        else $error("power fail flag not cleared by written one");
    a_flag_keep: assert property (
        flags_r[TMO_BIT] && !(sw_flag_wr && sw_flag_data[TMO_BIT])
            |=> flags_r[TMO_BIT])
        else $error("time-out flag lost without a written one");
    a_link_wake: assert property (
        flags_r[LOOP_BIT] && watchdog_en && !lps_s |=> link_wake_r)
        else $error("link layer not woken on loop");
    a_wake_off: assert property (
        !watchdog_en |=> !link_wake_r)
        else $error("link layer woken with watchdog disabled");
    a_pwr_fail: assert property (
        $past(sense_s) && !sense_s |-> ##1 flags_r[PWR_BIT])
        else $error("power fail flag missed falling edge");
    a_pwr_quiet: assert property (
        !flags_r[PWR_BIT] && !sense_fall |=> !flags_r[PWR_BIT])
        else $error("power fail flag set without a falling edge");
    a_timeout_rst: assert property (
        state_timeout |=> flags_r[TMO_BIT] && bus_reset_active
            && !bus_reset_short)
        else $error("state time-out without long bus reset");
    a_port_evt: assert property (
        |(port_chg & port_int_en) |=> flags_r[PEVT_BIT])
        else $error("port event flag missed enabled change");
    a_resume_evt: assert property (
        watchdog_en && |resume_start |=> flags_r[PEVT_BIT])
        else $error("port event flag missed resume start");
    a_pevt_quiet: assert property (
        !flags_r[PEVT_BIT] && !(|(port_chg & port_int_en))
            && !(watchdog_en && |resume_start) |=> !flags_r[PEVT_BIT])
        else $error("port event flag set without a cause");
    a_cfg_keep: assert property (
        !sw_cfg_wr |=> $stable({enab_accel_r, enab_multi_r,
                                page_sel_r, port_sel_r}))
        else $error("configuration changed without a write");
    a_page_zero: assert property (
        page_sel_r == STATUS_PAGE && int'(port_sel_r) >= NPORTS
            |=> port_page_rdata_r == '0)
        else $error("absent port status page not zero");

    c_short_rst: cover property (short_launch && !legacy_phy_present);
    c_long_sub: cover property (short_launch && legacy_phy_present);
    c_timeout: cover property (state_timeout ##1 bus_reset_active);
    c_wake: cover property (link_wake_r);
    c_pwr_fail: cover property (sense_fall ##1 flags_r[PWR_BIT]);
endmodule

// ---- sbp_peer_model.sv ----
`timescale 1ns/1ps
module sbp_peer_model (
    // Requests from the bench
    input wire logic supply_ok,
    input wire logic link_on,
    // Pins seen by the block, changing off the clock edge
    output logic cable_supply_sense,
    output logic link_power_status
);
    // Asynchronous pins, so they are skewed away from the sampling edge
    assign #3 cable_supply_sense = supply_ok;
    assign #3 link_power_status = link_on;
endmodule

// ---- test_serial_bus_phy_base_control_flags.sv ----
`timescale 1ns/1ps
module test_serial_bus_phy_base_control_flags
    import sbp_pkg::*;
();
    localparam int LC = 300;
    logic mclk, rst, sw_short_req_wr, sw_short_req_data;
    logic sw_flag_wr, sw_cfg_wr;
    logic cfg_accel_in, cfg_multi_in, watchdog_en, reset_opportunity;
    logic legacy_phy_present, peer_bus_reset, arb_tree_timeout;
    logic state_timeout, bias_report_dis, supply_ok, link_on, brst;
    logic port_bias, port_con, port_dis, port_fault, port_int_en;
    logic resume_start, supply_pin, lps, sreq, accel, multi, bra, brs, wake;
    logic [3:0] sw_flag_data, cfg_port_in, flags, port;
    logic [2:0] cfg_page_in, port_page_addr, page;
    logic [63:0] port_page_rows;
    logic [7:0] rdata;
    int errors, check_count, cyc, n;
    logic s;

    sbp_peer_model peer_u (.supply_ok, .link_on,
        .cable_supply_sense(supply_pin), .link_power_status(lps));

    sbp_base_ctrl #(.NPORTS(1), .LONG_CYC(LC)) dut_u (
        .mclk, .rst, .sw_short_req_wr, .sw_short_req_data, .sw_flag_wr,
        .sw_flag_data, .sw_cfg_wr, .cfg_accel_in, .cfg_multi_in,
        .cfg_page_in, .cfg_port_in, .watchdog_en,
        .cable_supply_sense(supply_pin), .link_power_status(lps),
        .reset_opportunity, .legacy_phy_present, .peer_bus_reset,
        .arb_tree_timeout, .state_timeout, .port_bias, .port_con,
        .port_dis, .port_fault, .port_int_en, .bias_report_dis,
        .resume_start, .port_page_addr, .port_page_rows,
        .port_page_rdata_r(rdata), .short_reset_request_r(sreq),
        .flags_r(flags), .enab_accel_r(accel), .enab_multi_r(multi),
        .page_sel_r(page), .port_sel_r(port), .bus_reset_active(bra),
        .bus_reset_short(brs), .bus_reset_start(brst), .link_wake_r(wake));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic chk_len(input string what, input int exp, input int got);
        check_count++;
        if (got != exp) begin
            errors++;
            $display("ERROR %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask

    task automatic pulse(ref logic sig);
        sig = 1'b1;
        tick(1);
        sig = 1'b0;
    endtask

    task automatic flag_wr(input logic [3:0] d);
        sw_flag_data = d;
        pulse(sw_flag_wr);
    endtask

    task automatic cfg_wr(input logic [2:0] pg, input logic [3:0] pt);
        cfg_page_in = pg;
        cfg_port_in = pt;
        pulse(sw_cfg_wr);
    endtask

    // Waits for a bus reset, returns its length and kind
    task automatic meas(output int len, output logic kind);
        int k;
        len = 0;
        k = 0;
        kind = 1'bx;
        while (bra !== 1'b1 && k < 20) begin
            tick(1);
            k++;
        end
        kind = brs;
        while (bra === 1'b1 && len < LC + 20) begin
            tick(1);
            len++;
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            final_report;
        end
    end

    initial begin
        {rst, supply_ok, link_on} = 3'h7;
        {sw_short_req_wr, sw_short_req_data, sw_flag_wr, sw_cfg_wr} = 4'h0;
        {cfg_accel_in, cfg_multi_in, watchdog_en, reset_opportunity} = 4'h0;
        {legacy_phy_present, peer_bus_reset, arb_tree_timeout} = 3'h0;
        {state_timeout, bias_report_dis, port_bias, port_con} = 4'h0;
        {port_dis, port_fault, port_int_en, resume_start} = 4'h0;
        {sw_flag_data, cfg_port_in, cfg_page_in, port_page_addr} = 14'h0;
        port_page_rows = 64'h8877665544332211;
        tick(6);
        rst = 1'b0;
        chk("flags", 8'h00, {4'h0, flags});
        chk("accel", 8'h00, {7'h0, accel});
        chk("multi", 8'h00, {7'h0, multi});
        chk("page", 8'h00, {5'h0, page});
        chk("port", 8'h00, {4'h0, port});
        chk("start", 8'h00, {7'h0, brst});
        $display("test reset_values done");

        {cfg_accel_in, cfg_multi_in, sw_short_req_data} = 3'h7;
        cfg_wr(3'h5, 4'h9);
        pulse(sw_short_req_wr);
        chk("request", 8'h01, {7'h0, sreq});
        peer_bus_reset = 1'b1;
        #1;
        chk("start", 8'h01, {7'h0, brst});
        tick(1);
        peer_bus_reset = 1'b0;
        tick(1);
        chk("request", 8'h00, {7'h0, sreq});
        chk("accel", 8'h01, {7'h0, accel});
        chk("multi", 8'h01, {7'h0, multi});
        chk("page", 8'h05, {5'h0, page});
        chk("port", 8'h09, {4'h0, port});
        $display("test config_keep done");

        port_page_addr = 3'h3;
        cfg_wr(3'h0, 4'h0);
        tick(2);
        chk("row", 8'h44, rdata);
        cfg_wr(3'h0, 4'h1);
        tick(2);
        chk("row", 8'h00, rdata);
        $display("test status_page done");

        reset_opportunity = 1'b1;
        pulse(sw_short_req_wr);
        meas(n, s);
        chk_len("short len", SHORT_RST_CYC, n);
        chk("kind", 8'h01, {7'h0, s});
        chk("request", 8'h00, {7'h0, sreq});
        legacy_phy_present = 1'b1;
        pulse(sw_short_req_wr);
        meas(n, s);
        chk_len("long len", LC, n);
        chk("kind", 8'h00, {7'h0, s});
        $display("test short_reset done");

        legacy_phy_present = 1'b0;
        pulse(state_timeout);
        meas(n, s);
        chk_len("timeout len", LC, n);
        chk("kind", 8'h00, {7'h0, s});
        chk("flags", 8'h04, {4'h0, flags});
        pulse(arb_tree_timeout);
        tick(2);
        chk("flags", 8'h05, {4'h0, flags});
        chk("bus reset", 8'h00, {7'h0, bra});
        flag_wr(4'h0);
        chk("flags", 8'h05, {4'h0, flags});
        watchdog_en = 1'b1;
        link_on = 1'b0;
        tick(6);
        chk("wake", 8'h01, {7'h0, wake});
        {link_on, watchdog_en} = 2'h2;
        supply_ok = 1'b0;
        tick(6);
        chk("flags", 8'h07, {4'h0, flags});
        {port_int_en, port_con} = 2'h3;
        tick(2);
        chk("flags", 8'h0F, {4'h0, flags});
        flag_wr(4'hF);
        chk("flags", 8'h00, {4'h0, flags});
        {bias_report_dis, port_bias} = 2'h3;
        tick(2);
        chk("flags", 8'h00, {4'h0, flags});
        {port_int_en, watchdog_en} = 2'h1;
        pulse(resume_start);
        tick(1);
        chk("flags", 8'h08, {4'h0, flags});
        $display("test events done");

        cfg_wr(3'h6, 4'h2);
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        chk("flags", 8'h00, {4'h0, flags});
        chk("accel", 8'h00, {7'h0, accel});
        chk("multi", 8'h00, {7'h0, multi});
        chk("page", 8'h00, {5'h0, page});
        chk("port", 8'h00, {4'h0, port});
        $display("test system_reset done");
        final_report;
    end
endmodule
